// File: rtl/ccpll_defines.vh
// register map, field positions and reset values of the codec clock tree
`ifndef CCPLL_DEFINES_VH
`define CCPLL_DEFINES_VH
// register offsets
`define CCPLL_ADDR_ROOT_SEL 8'h04
`define CCPLL_ADDR_PLL_PR 8'h05
`define CCPLL_ADDR_PLL_J 8'h06
`define CCPLL_ADDR_PLL_DMSB 8'h07
`define CCPLL_ADDR_PLL_DLSB 8'h08
`define CCPLL_ADDR_DAC_PREDIV 8'h0b
`define CCPLL_ADDR_DAC_MOD 8'h0c
`define CCPLL_ADDR_DAC_OVERSAMPLE_MSB 8'h0d
`define CCPLL_ADDR_DAC_OVERSAMPLE_LSB 8'h0e
`define CCPLL_ADDR_ADC_PREDIV 8'h12
`define CCPLL_ADDR_ADC_MOD 8'h13
`define CCPLL_ADDR_ADC_OVERSAMPLE_DIVIDER 8'h14
`define CCPLL_ADDR_GP_SEL 8'h19
`define CCPLL_ADDR_GP_DIV 8'h1a
`define CCPLL_ADDR_IFACE 8'h1b
`define CCPLL_ADDR_BCLK_SEL 8'h1d
`define CCPLL_ADDR_BCLK_DIV 8'h1e
`define CCPLL_ADDR_ADC_FLAGS 8'h24
`define CCPLL_ADDR_DAC_FLAGS 8'h25
`define CCPLL_ADDR_GP_ROUTE 8'h34
// field positions
`define CCPLL_EN_BIT 7
`define CCPLL_IFACE_BCLK_OUT_BIT 3
`define CCPLL_ADC_FLAG_BIT 6
`define CCPLL_DAC_FLAG_A_BIT 7
`define CCPLL_DAC_FLAG_B_BIT 3
`define CCPLL_GP_ROUTE_EN_BIT 2
// reset values
`define CCPLL_RST_ROOT_SEL 8'h00
`define CCPLL_RST_PLL_PR 8'h11
`define CCPLL_RST_PLL_J 8'h04
`define CCPLL_RST_ZERO 8'h00
`define CCPLL_RST_DIV 8'h01
`define CCPLL_RST_DAC_OVERSAMPLE_LSB 8'h80
`define CCPLL_RST_ADC_OVERSAMPLE_DIVIDER 8'h80
// divider full counts for a zero field
`define CCPLL_FULL_7 11'h080
`define CCPLL_FULL_8 11'h100
`define CCPLL_FULL_10 11'h400
`define CCPLL_FULL_P 17'h00008
`define CCPLL_FULL_R 24'h000010
`define CCPLL_FULL_J 20'h00000
// fraction scale of j.d
`define CCPLL_FRAC_SCALE 20'h02710
`define CCPLL_FRAC_SCALE17 17'h02710
// root and source selector codes
`define CCPLL_SRC_MCLK 3'h0
`define CCPLL_SRC_BCLK 3'h1
`define CCPLL_SRC_GPIO 3'h2
`define CCPLL_SRC_PLL 3'h3
`define CCPLL_SRC_DAC_PROC 3'h4
`define CCPLL_SRC_DAC_MOD 3'h5
`define CCPLL_SRC_ADC_PROC 3'h6
`define CCPLL_SRC_ADC_MOD 3'h7
`endif

// File: rtl/ccpll_tick_div.v
// clock-enable divider: one output tick per ratio input ticks
`timescale 1ns/10ps
module ccpll_tick_div (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// source and control
	input wire tick_in,
	input wire enable,
	input wire [10:0] ratio,
	// divided tick
	output reg tick_out
);
	reg [10:0] cnt_reg;

	always @(posedge core_clk) begin
		if (!rstn || !enable) begin
			cnt_reg <= 11'h000;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (cnt_reg >= ratio - 11'h001) begin
					cnt_reg <= 11'h000;
					tick_out <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 11'h001;
				end
			end
		end
	end
endmodule // ccpll_tick_div

// File: rtl/ccpll_clk_out.v
// pin clock generator: square wave with a period of ratio source ticks
`timescale 1ns/10ps
module ccpll_clk_out (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// source and control
	input wire tick_in,
	input wire enable,
	input wire [7:0] ratio,
	// pin level
	output reg clk_out
);
	reg [7:0] cnt_reg;
	wire [7:0] half;
	wire [7:0] cnt_next;

	assign half = (ratio + 8'h01) >> 1;
	assign cnt_next = (cnt_reg >= ratio - 8'h01) ? 8'h00 : cnt_reg + 8'h01;

	always @(posedge core_clk) begin
		if (!rstn || !enable) begin
			cnt_reg <= 8'h00;
			clk_out <= 1'b0;
		end else if (ratio == 8'h01) begin
			clk_out <= tick_in;
		end else if (tick_in) begin
			cnt_reg <= cnt_next;
			clk_out <= (cnt_next < half);
		end
	end
endmodule // ccpll_clk_out

// File: rtl/ccpll_top.v
// codec clock tree: root select, fractional pll, dac/adc dividers, pin clocks
// Function
// - dac: two 7-bit dividers, 10-bit oversample divider
// - adc: two 7-bit dividers, 8-bit oversample divider
// - bit 7 gates each dac divider
// - both adc dividers off: use dac chain
// - bit clock out: source divided 1 to 128
// - bit clock source among four internal clocks
// - general clock out, divided, routable to pins
// - 3-bit selector picks general clock source
// - pll enable; out = in*r*j.d/p
// - p in bits 6:4, 1..8, reset 1
// - r in bits 3:0, 1..16, reset 1
// - j in bits 5:0, 0..63, reset 4
// - 14-bit fraction split msb/lsb, reset 0
// - fraction applied on lsb write
// - root clock from mclk, bclk, gpio, pll
`timescale 1ns/10ps
`include "ccpll_defines.vh"
module ccpll_top (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// reference clock pins
	input wire mclk_pin,
	input wire bclk_pin,
	input wire general_pin_one_in,
	// register port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// codec power status
	input wire adc_powered_down,
	input wire dac_left_powered_down,
	input wire dac_right_powered_down,
	// internal clock enables
	output reg pll_clock_en,
	output reg dac_processor_clock_en,
	output reg dac_modulator_clock_en,
	output reg dac_sample_en,
	output reg adc_processor_clock_en,
	output reg adc_modulator_clock_en,
	output reg adc_sample_en,
	// bit clock pin
	output reg bclk_out,
	output reg bclk_oe,
	// general clock pins
	output reg general_pin_one_out,
	output reg general_pin_one_oe,
	output reg general_pin_two_out,
	output reg general_pin_two_oe,
	output reg serial_audio_out_pin_out,
	output reg serial_audio_out_pin_oe,
	output reg spi_data_out_out,
	output reg spi_data_out_oe
);
	// zero field means the full count
	function [10:0] div_count;
		input [9:0] field;
		input [10:0] full;
		begin
			div_count = (field == 10'h000) ? full : {1'b0, field};
		end
	endfunction

	// registers
	reg [7:0] root_sel_reg;
	reg [7:0] pll_pr_reg;
	reg [7:0] pll_j_reg;
	reg [5:0] frac_msb_reg;
	reg [7:0] frac_lsb_reg;
	reg [13:0] frac_live_reg;
	reg [7:0] dac_prediv_reg;
	reg [7:0] dac_mod_reg;
	reg [1:0] dac_oversample_msb_reg;
	reg [7:0] dac_oversample_lsb_reg;
	reg [7:0] adc_prediv_reg;
	reg [7:0] adc_mod_reg;
	reg [7:0] adc_oversample_divider_reg;
	reg [2:0] gp_sel_reg;
	reg [7:0] gp_div_reg;
	reg [7:0] iface_reg;
	reg [1:0] bclk_sel_reg;
	reg [7:0] bclk_div_reg;
	reg [2:0] gp_route_reg;
	reg [7:0] rdata_next;

	// pin synchronisers and edge detectors
	reg [2:0] mclk_sync_reg;
	reg [2:0] bclk_sync_reg;
	reg [2:0] gpio_sync_reg;
	wire mclk_edge;
	wire bclk_edge;
	wire gpio_edge;

	always @(posedge core_clk) begin
		if (!rstn) begin
			mclk_sync_reg <= 3'h0;
			bclk_sync_reg <= 3'h0;
			gpio_sync_reg <= 3'h0;
		end else begin
			mclk_sync_reg <= {mclk_sync_reg[1:0], mclk_pin};
			bclk_sync_reg <= {bclk_sync_reg[1:0], bclk_pin};
			gpio_sync_reg <= {gpio_sync_reg[1:0], general_pin_one_in};
		end
	end
	assign mclk_edge = mclk_sync_reg[1] & ~mclk_sync_reg[2];
	assign bclk_edge = bclk_sync_reg[1] & ~bclk_sync_reg[2];
	assign gpio_edge = gpio_sync_reg[1] & ~gpio_sync_reg[2];

	// register writes
	always @(posedge core_clk) begin
		if (!rstn) begin
			root_sel_reg <= `CCPLL_RST_ROOT_SEL;
			pll_pr_reg <= `CCPLL_RST_PLL_PR;
			pll_j_reg <= `CCPLL_RST_PLL_J;
			frac_msb_reg <= 6'h00;
			frac_lsb_reg <= `CCPLL_RST_ZERO;
			frac_live_reg <= 14'h0000;
			dac_prediv_reg <= `CCPLL_RST_DIV;
			dac_mod_reg <= `CCPLL_RST_DIV;
			dac_oversample_msb_reg <= 2'h0;
			dac_oversample_lsb_reg <= `CCPLL_RST_DAC_OVERSAMPLE_LSB;
			adc_prediv_reg <= `CCPLL_RST_DIV;
			adc_mod_reg <= `CCPLL_RST_DIV;
			adc_oversample_divider_reg <= `CCPLL_RST_ADC_OVERSAMPLE_DIVIDER;
			gp_sel_reg <= 3'h0;
			gp_div_reg <= `CCPLL_RST_DIV;
			iface_reg <= `CCPLL_RST_ZERO;
			bclk_sel_reg <= 2'h0;
			bclk_div_reg <= `CCPLL_RST_DIV;
			gp_route_reg <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				`CCPLL_ADDR_ROOT_SEL: root_sel_reg <= {4'h0, reg_wdata[3:0]};
				`CCPLL_ADDR_PLL_PR: pll_pr_reg <= reg_wdata;
				`CCPLL_ADDR_PLL_J: pll_j_reg <= {2'h0, reg_wdata[5:0]};
				`CCPLL_ADDR_PLL_DMSB: frac_msb_reg <= reg_wdata[5:0];
				`CCPLL_ADDR_PLL_DLSB: begin
					frac_lsb_reg <= reg_wdata;
					frac_live_reg <= {frac_msb_reg, reg_wdata};
				end
				`CCPLL_ADDR_DAC_PREDIV: dac_prediv_reg <= reg_wdata;
				`CCPLL_ADDR_DAC_MOD: dac_mod_reg <= reg_wdata;
				`CCPLL_ADDR_DAC_OVERSAMPLE_MSB: dac_oversample_msb_reg <= reg_wdata[1:0];
				`CCPLL_ADDR_DAC_OVERSAMPLE_LSB: dac_oversample_lsb_reg <= reg_wdata;
				`CCPLL_ADDR_ADC_PREDIV: adc_prediv_reg <= reg_wdata;
				`CCPLL_ADDR_ADC_MOD: adc_mod_reg <= reg_wdata;
				`CCPLL_ADDR_ADC_OVERSAMPLE_DIVIDER: adc_oversample_divider_reg <= reg_wdata;
				`CCPLL_ADDR_GP_SEL: gp_sel_reg <= reg_wdata[2:0];
				`CCPLL_ADDR_GP_DIV: gp_div_reg <= reg_wdata;
				`CCPLL_ADDR_IFACE: iface_reg <= reg_wdata;
				`CCPLL_ADDR_BCLK_SEL: bclk_sel_reg <= reg_wdata[1:0];
				`CCPLL_ADDR_BCLK_DIV: bclk_div_reg <= reg_wdata;
				`CCPLL_ADDR_GP_ROUTE: gp_route_reg <= reg_wdata[2:0];
				default: root_sel_reg <= root_sel_reg;
			endcase
		end
	end

	// register reads
	always @* begin
		case (reg_addr)
			`CCPLL_ADDR_ROOT_SEL: rdata_next = root_sel_reg;
			`CCPLL_ADDR_PLL_PR: rdata_next = pll_pr_reg;
			`CCPLL_ADDR_PLL_J: rdata_next = pll_j_reg;
			`CCPLL_ADDR_PLL_DMSB: rdata_next = {2'h0, frac_msb_reg};
			`CCPLL_ADDR_PLL_DLSB: rdata_next = frac_lsb_reg;
			`CCPLL_ADDR_DAC_PREDIV: rdata_next = dac_prediv_reg;
			`CCPLL_ADDR_DAC_MOD: rdata_next = dac_mod_reg;
			`CCPLL_ADDR_DAC_OVERSAMPLE_MSB: rdata_next = {6'h00, dac_oversample_msb_reg};
			`CCPLL_ADDR_DAC_OVERSAMPLE_LSB: rdata_next = dac_oversample_lsb_reg;
			`CCPLL_ADDR_ADC_PREDIV: rdata_next = adc_prediv_reg;
			`CCPLL_ADDR_ADC_MOD: rdata_next = adc_mod_reg;
			`CCPLL_ADDR_ADC_OVERSAMPLE_DIVIDER: rdata_next = adc_oversample_divider_reg;
			`CCPLL_ADDR_GP_SEL: rdata_next = {5'h00, gp_sel_reg};
			`CCPLL_ADDR_GP_DIV: rdata_next = gp_div_reg;
			`CCPLL_ADDR_IFACE: rdata_next = iface_reg;
			`CCPLL_ADDR_BCLK_SEL: rdata_next = {6'h00, bclk_sel_reg};
			`CCPLL_ADDR_BCLK_DIV: rdata_next = bclk_div_reg;
			`CCPLL_ADDR_GP_ROUTE: rdata_next = {5'h00, gp_route_reg};
			`CCPLL_ADDR_ADC_FLAGS: rdata_next = {1'b0, adc_powered_down, 6'h00};
			`CCPLL_ADDR_DAC_FLAGS: rdata_next = {dac_left_powered_down, 3'h0, dac_right_powered_down, 3'h0};
			default: rdata_next = 8'h00;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

	// fractional pll as a tick rate multiplier
	reg pll_in_edge;
	reg [26:0] pll_acc_reg;
	reg pll_tick_reg;
	wire pll_on;
	wire [19:0] j_ext;
	wire [19:0] jd_value;
	wire [23:0] r_value;
	wire [23:0] pll_inc;
	wire [16:0] p_value;
	wire [16:0] pll_thresh;
	wire [26:0] pll_sum;

	assign pll_on = pll_pr_reg[`CCPLL_EN_BIT];
	assign j_ext = {14'h0000, pll_j_reg[5:0]};
	assign jd_value = j_ext * `CCPLL_FRAC_SCALE + {6'h00, frac_live_reg};
	assign r_value = (pll_pr_reg[3:0] == 4'h0) ? `CCPLL_FULL_R : {20'h00000, pll_pr_reg[3:0]};
	assign p_value = (pll_pr_reg[6:4] == 3'h0) ? `CCPLL_FULL_P : {14'h0000, pll_pr_reg[6:4]};
	assign pll_inc = r_value * {4'h0, jd_value};
	assign pll_thresh = p_value * `CCPLL_FRAC_SCALE17;
	assign pll_sum = (pll_in_edge && !pll_acc_reg[26]) ? pll_acc_reg + {3'h0, pll_inc} : pll_acc_reg;

	// pll input select
	always @* begin
		case (root_sel_reg[3:2])
			2'h1: pll_in_edge = bclk_edge;
			2'h2: pll_in_edge = gpio_edge;
			default: pll_in_edge = mclk_edge;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rstn || !pll_on) begin
			pll_acc_reg <= 27'h0000000;
			pll_tick_reg <= 1'b0;
		end else if (pll_sum >= {10'h000, pll_thresh}) begin
			pll_acc_reg <= pll_sum - {10'h000, pll_thresh};
			pll_tick_reg <= 1'b1;
		end else begin
			pll_acc_reg <= pll_sum;
			pll_tick_reg <= 1'b0;
		end
	end

	// root clock select
	reg root_tick;
	always @* begin
		case (root_sel_reg[1:0])
			`CCPLL_SRC_MCLK: root_tick = mclk_edge;
			`CCPLL_SRC_BCLK: root_tick = bclk_edge;
			`CCPLL_SRC_GPIO: root_tick = gpio_edge;
			default: root_tick = pll_tick_reg;
		endcase
	end

	// dac chain
	wire dac_proc_tick;
	wire dac_mod_tick;
	wire dac_fs_tick;
	wire dac_pre_en;
	wire dac_mod_en;

	assign dac_pre_en = dac_prediv_reg[`CCPLL_EN_BIT];
	assign dac_mod_en = dac_mod_reg[`CCPLL_EN_BIT];

	ccpll_tick_div u_dac_prediv (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(root_tick),
		.enable(dac_pre_en),
		.ratio(div_count({3'h0, dac_prediv_reg[6:0]}, `CCPLL_FULL_7)),
		.tick_out(dac_proc_tick)
	);

	ccpll_tick_div u_dac_mod (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(dac_proc_tick),
		.enable(dac_mod_en),
		.ratio(div_count({3'h0, dac_mod_reg[6:0]}, `CCPLL_FULL_7)),
		.tick_out(dac_mod_tick)
	);

	ccpll_tick_div u_dac_osr (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(dac_mod_tick),
		.enable(dac_mod_en),
		.ratio(div_count({dac_oversample_msb_reg, dac_oversample_lsb_reg}, `CCPLL_FULL_10)),
		.tick_out(dac_fs_tick)
	);

	// adc chain, falling back to the dac chain
	wire adc_pre_en;
	wire adc_mod_en;
	wire adc_use_dac;
	wire adc_pre_tick;
	wire adc_mod_tick;
	wire adc_proc_sel;
	wire adc_mod_sel;
	wire adc_fs_tick;

	assign adc_pre_en = adc_prediv_reg[`CCPLL_EN_BIT];
	assign adc_mod_en = adc_mod_reg[`CCPLL_EN_BIT];
	assign adc_use_dac = !adc_pre_en && !adc_mod_en;
	assign adc_proc_sel = adc_use_dac ? dac_proc_tick : adc_pre_tick;
	assign adc_mod_sel = adc_use_dac ? dac_mod_tick : adc_mod_tick;

	ccpll_tick_div u_adc_prediv (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(root_tick),
		.enable(adc_pre_en),
		.ratio(div_count({3'h0, adc_prediv_reg[6:0]}, `CCPLL_FULL_7)),
		.tick_out(adc_pre_tick)
	);

	ccpll_tick_div u_adc_mod (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(adc_pre_tick),
		.enable(adc_mod_en),
		.ratio(div_count({3'h0, adc_mod_reg[6:0]}, `CCPLL_FULL_7)),
		.tick_out(adc_mod_tick)
	);

	ccpll_tick_div u_adc_osr (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(adc_mod_sel),
		.enable(adc_use_dac ? dac_mod_en : adc_mod_en),
		.ratio(div_count({2'h0, adc_oversample_divider_reg}, `CCPLL_FULL_8)),
		.tick_out(adc_fs_tick)
	);

	// bit clock output
	reg bclk_src_tick;
	wire bclk_drive;
	wire bclk_level;
	wire [10:0] bclk_ratio;

	always @* begin
		case (bclk_sel_reg)
			2'h0: bclk_src_tick = dac_proc_tick;
			2'h1: bclk_src_tick = dac_mod_tick;
			2'h2: bclk_src_tick = adc_proc_sel;
			default: bclk_src_tick = adc_mod_sel;
		endcase
	end
	assign bclk_drive = iface_reg[`CCPLL_IFACE_BCLK_OUT_BIT];
	assign bclk_ratio = div_count({3'h0, bclk_div_reg[6:0]}, `CCPLL_FULL_7);

	ccpll_clk_out u_bclk_out (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(bclk_src_tick),
		.enable(bclk_drive && bclk_div_reg[`CCPLL_EN_BIT]),
		.ratio(bclk_ratio[7:0]),
		.clk_out(bclk_level)
	);

	// general clock output
	reg gp_src_tick;
	wire gp_level;
	wire [10:0] gp_ratio;
	assign gp_ratio = div_count({3'h0, gp_div_reg[6:0]}, `CCPLL_FULL_7);

	always @* begin
		case (gp_sel_reg)
			`CCPLL_SRC_MCLK: gp_src_tick = mclk_edge;
			`CCPLL_SRC_BCLK: gp_src_tick = bclk_edge;
			`CCPLL_SRC_GPIO: gp_src_tick = gpio_edge;
			`CCPLL_SRC_PLL: gp_src_tick = pll_tick_reg;
			`CCPLL_SRC_DAC_PROC: gp_src_tick = dac_proc_tick;
			`CCPLL_SRC_DAC_MOD: gp_src_tick = dac_mod_tick;
			`CCPLL_SRC_ADC_PROC: gp_src_tick = adc_proc_sel;
			default: gp_src_tick = adc_mod_sel;
		endcase
	end

	ccpll_clk_out u_gp_out (
		.core_clk(core_clk),
		.rstn(rstn),
		.tick_in(gp_src_tick),
		.enable(gp_div_reg[`CCPLL_EN_BIT]),
		.ratio(gp_ratio[7:0]),
		.clk_out(gp_level)
	);

	// registered outputs
	wire gp_route_on;
	assign gp_route_on = gp_route_reg[`CCPLL_GP_ROUTE_EN_BIT];

	always @(posedge core_clk) begin
		if (!rstn) begin
			pll_clock_en <= 1'b0;
			dac_processor_clock_en <= 1'b0;
			dac_modulator_clock_en <= 1'b0;
			dac_sample_en <= 1'b0;
			adc_processor_clock_en <= 1'b0;
			adc_modulator_clock_en <= 1'b0;
			adc_sample_en <= 1'b0;
			bclk_out <= 1'b0;
			bclk_oe <= 1'b0;
			general_pin_one_out <= 1'b0;
			general_pin_one_oe <= 1'b0;
			general_pin_two_out <= 1'b0;
			general_pin_two_oe <= 1'b0;
			serial_audio_out_pin_out <= 1'b0;
			serial_audio_out_pin_oe <= 1'b0;
			spi_data_out_out <= 1'b0;
			spi_data_out_oe <= 1'b0;
		end else begin
			pll_clock_en <= pll_tick_reg;
			dac_processor_clock_en <= dac_proc_tick;
			dac_modulator_clock_en <= dac_mod_tick;
			dac_sample_en <= dac_fs_tick;
			adc_processor_clock_en <= adc_proc_sel;
			adc_modulator_clock_en <= adc_mod_sel;
			adc_sample_en <= adc_fs_tick;
			bclk_out <= bclk_level;
			bclk_oe <= bclk_drive;
			general_pin_one_out <= gp_level;
			general_pin_one_oe <= gp_route_on && (gp_route_reg[1:0] == 2'h0);
			general_pin_two_out <= gp_level;
			general_pin_two_oe <= gp_route_on && (gp_route_reg[1:0] == 2'h1);
			serial_audio_out_pin_out <= gp_level;
			serial_audio_out_pin_oe <= gp_route_on && (gp_route_reg[1:0] == 2'h2);
			spi_data_out_out <= gp_level;
			spi_data_out_oe <= gp_route_on && (gp_route_reg[1:0] == 2'h3);
		end
	end
endmodule // ccpll_top

// File: testbench/ccpll_checker.sv
// port assertions for the codec clock tree
`timescale 1ns/10ps
module ccpll_checker (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// register port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	// power status
	input wire adc_powered_down,
	input wire dac_left_powered_down,
	input wire dac_right_powered_down,
	// clock enables and pin drives
	input wire pll_clock_en,
	input wire dac_processor_clock_en,
	input wire dac_modulator_clock_en,
	input wire dac_sample_en,
	input wire adc_modulator_clock_en,
	input wire adc_sample_en,
	input wire bclk_oe,
	input wire general_pin_one_oe,
	input wire general_pin_two_oe,
	input wire serial_audio_out_pin_oe,
	input wire spi_data_out_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_reset_quiet: assert property ($rose(rstn) |-> !(pll_clock_en | dac_processor_clock_en | bclk_oe))
		else $error("output active right after reset");
	a_gp_onehot: assert property ($onehot0({general_pin_one_oe, general_pin_two_oe, serial_audio_out_pin_oe,
		spi_data_out_oe}))
		else $error("more than one general clock pin driven");
	a_route_pin_two: assert property ((reg_wr && reg_addr == 8'h34 && reg_wdata[2:0] == 3'h5) ##1 (!reg_wr)[*2]
		|-> general_pin_two_oe)
		else $error("general clock not driven on second pin");
	a_bclk_drive: assert property (reg_wr && reg_addr == 8'h1b && reg_wdata[3] |-> ##[1:3] bclk_oe)
		else $error("bit clock pin not driven");
	a_bclk_release: assert property (reg_wr && reg_addr == 8'h1b && !reg_wdata[3] |-> ##[1:3] !bclk_oe)
		else $error("bit clock pin still driven");
	a_adc_flag_read: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata == {1'b0, $past(adc_powered_down),
		6'h00})
		else $error("adc power flag read wrong");
	a_dac_flag_read: assert property (reg_rd && reg_addr == 8'h25 |=> reg_rdata == {$past(dac_left_powered_down),
		3'h0, $past(dac_right_powered_down), 3'h0})
		else $error("dac power flags read wrong");
	a_pll_stopped: assert property ((reg_wr && reg_addr == 8'h05 && !reg_wdata[7]) ##1 (!reg_wr)[*8]
		|-> !pll_clock_en)
		else $error("pll ticks while disabled");
	a_dac_gated: assert property ((reg_wr && reg_addr == 8'h0b && !reg_wdata[7]) ##1 (!reg_wr)[*8]
		|-> !dac_processor_clock_en)
		else $error("dac processor clock while gated");
	a_mod_cause: assert property (dac_modulator_clock_en |-> dac_processor_clock_en
		|| $past(dac_processor_clock_en) || $past(dac_processor_clock_en, 2))
		else $error("dac modulator pulse without processor pulse");
	a_adc_sample_cause: assert property (adc_sample_en |-> adc_modulator_clock_en
		|| $past(adc_modulator_clock_en) || $past(adc_modulator_clock_en, 2))
		else $error("adc sample pulse without modulator pulse");
	c_dac_sample: cover property (dac_sample_en);
	c_adc_sample: cover property (adc_sample_en);
	c_pll_tick: cover property (pll_clock_en);
endmodule // ccpll_checker

// File: testbench/ccpll_host_model.sv
// host software and codec power status model
`timescale 1ns/10ps
module ccpll_host_model (
	// clock
	input wire core_clk,
	// register port
	output reg reg_wr,
	output reg reg_rd,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	// codec power status
	output reg adc_powered_down,
	output reg dac_left_powered_down,
	output reg dac_right_powered_down
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		flags(1'b0, 1'b0, 1'b0);
	end
	task flags(input a, input l, input r);
		begin
			adc_powered_down = a;
			dac_left_powered_down = l;
			dac_right_powered_down = r;
		end
	endtask
	// idle bus shows inverted last value
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge core_clk);
			#1;
			reg_wr = 1'b1;
			reg_addr = a;
			reg_wdata = d;
			@(posedge core_clk);
			#1;
			reg_wr = 1'b0;
			reg_addr = ~a;
			reg_wdata = ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge core_clk);
			#1;
			reg_rd = 1'b1;
			reg_addr = a;
			@(posedge core_clk);
			#1;
			d = reg_rdata;
			reg_rd = 1'b0;
			reg_addr = ~a;
		end
	endtask
	// codec reports power-down, then dividers off, child first
	task dac_shutdown(input [7:0] n, input [7:0] m);
		reg [7:0] st;
		begin
			dac_left_powered_down = 1'b1;
			repeat (5) @(posedge core_clk);
			#1 dac_right_powered_down = 1'b1;
			st = 8'h00;
			while ((st & 8'h88) != 8'h88)
				rd(8'h25, st);
			wr(8'h0c, m & 8'h7f);
			wr(8'h0b, n & 8'h7f);
		end
	endtask
endmodule // ccpll_host_model

// File: testbench/ccpll_top_bench.sv
// self-checking bench for the codec clock tree
`timescale 1ns/10ps
module ccpll_top_bench;
	reg core_clk;
	reg rstn;
	reg mclk_pin;
	wire bclk_pin = 1'b0;
	wire general_pin_one_in = 1'b0;
	wire reg_wr, reg_rd, adc_powered_down, dac_left_powered_down, dac_right_powered_down;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire pll_clock_en, dac_processor_clock_en, dac_modulator_clock_en, dac_sample_en;
	wire adc_processor_clock_en, adc_modulator_clock_en, adc_sample_en, bclk_out, bclk_oe;
	wire general_pin_one_out, general_pin_one_oe, general_pin_two_out, general_pin_two_oe;
	wire serial_audio_out_pin_out, serial_audio_out_pin_oe, spi_data_out_out, spi_data_out_oe;
	wire [3:0] gp_oe = {spi_data_out_oe, serial_audio_out_pin_oe, general_pin_two_oe, general_pin_one_oe};
	wire gp_level = |({spi_data_out_out, serial_audio_out_pin_out, general_pin_two_out, general_pin_one_out} & gp_oe);
	wire [8:0] ev = {gp_level, bclk_out, adc_sample_en, adc_modulator_clock_en, adc_processor_clock_en,
		dac_sample_en, dac_modulator_clock_en, dac_processor_clock_en, pll_clock_en};
	// reset table: address, value; 0x09 is unmapped
	localparam [335:0] RST = {16'h0400, 16'h0511, 16'h0604, 16'h0700, 16'h0800, 16'h0b01, 16'h0c01, 16'h0d00,
		16'h0e80, 16'h1201, 16'h1301, 16'h1480, 16'h1900, 16'h1a01, 16'h1b00, 16'h1d00, 16'h1e01, 16'h2400,
		16'h2500, 16'h3400, 16'h0900};
	integer n_errors, n_checks, i, k;
	integer c [0:8];
	integer s [0:8];
	reg [8:0] prev;
	ccpll_top dut (.core_clk, .rstn, .mclk_pin, .bclk_pin, .general_pin_one_in, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .adc_powered_down, .dac_left_powered_down, .dac_right_powered_down,
		.pll_clock_en, .dac_processor_clock_en, .dac_modulator_clock_en, .dac_sample_en,
		.adc_processor_clock_en, .adc_modulator_clock_en, .adc_sample_en, .bclk_out, .bclk_oe,
		.general_pin_one_out, .general_pin_one_oe, .general_pin_two_out, .general_pin_two_oe,
		.serial_audio_out_pin_out, .serial_audio_out_pin_oe, .spi_data_out_out, .spi_data_out_oe);
	ccpll_host_model host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.adc_powered_down, .dac_left_powered_down, .dac_right_powered_down);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		mclk_pin = 1'b0;
		forever #53 mclk_pin = ~mclk_pin;
	end
	// pulse counts, and rise counts of pin clocks
	always @(posedge core_clk) begin
		for (k = 0; k < 9; k = k + 1)
			if (k < 7 ? ev[k] : (ev[k] && !prev[k])) c[k] = c[k] + 1;
		prev <= ev;
	end
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task rchk(input [7:0] a, input [7:0] exp);
		reg [7:0] d;
		begin
			host.rd(a, d);
			chk(d, exp);
		end
	endtask
	// count over the last window, two of slack for pipeline edges
	task near(input integer idx, input integer exp);
		integer g;
		begin
			g = c[idx] - s[idx];
			n_checks = n_checks + 1;
			if (g < exp - 2 || g > exp + 2) begin
				n_errors = n_errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, exp);
			end
		end
	endtask
	// settle, then a window of 120 reference edges
	task meas;
		integer j;
		begin
			repeat (8) @(posedge mclk_pin);
			for (j = 0; j < 9; j = j + 1)
				s[j] = c[j];
			repeat (120) @(posedge mclk_pin);
			@(posedge core_clk);
			#1;
		end
	endtask
	task test_done;
		begin
			$display("checks=%0d errors=%0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		#600000;
		n_errors = n_errors + 1;
		test_done;
	end
	initial begin
		rstn = 1'b0;
		n_errors = 0;
		n_checks = 0;
		prev = 9'h000;
		for (i = 0; i < 9; i = i + 1)
			c[i] = 0;
		repeat (2) @(posedge core_clk);
		#1 rstn = 1'b1;
		for (i = 0; i < 21; i = i + 1)
			rchk(RST[i*16+8 +: 8], RST[i*16 +: 8]);
		host.flags(1'b1, 1'b0, 1'b1);
		rchk(8'h24, 8'h40);
		rchk(8'h25, 8'h08);
		host.flags(1'b0, 1'b1, 1'b0);
		host.wr(8'h24, 8'hff);
		rchk(8'h24, 8'h00);
		rchk(8'h25, 8'h80);
		host.flags(1'b0, 1'b0, 1'b0);
		host.wr(8'h0b, 8'h82);
		host.wr(8'h0c, 8'h83);
		host.wr(8'h0e, 8'h04);
		meas;
		near(1, 60);
		near(2, 20);
		near(3, 5);
		near(4, 60);
		near(5, 20);
		host.wr(8'h12, 8'h81);
		host.wr(8'h13, 8'h84);
		host.wr(8'h14, 8'h03);
		meas;
		near(4, 120);
		near(5, 30);
		near(6, 10);
		host.wr(8'h1b, 8'h08);
		host.wr(8'h1e, 8'h82);
		chk({7'h00, bclk_oe}, 8'h01);
		for (i = 0; i < 4; i = i + 1) begin
			host.wr(8'h1d, i[7:0]);
			meas;
			near(7, i == 0 ? 30 : i == 1 ? 10 : i == 2 ? 60 : 15);
		end
		host.wr(8'h1e, 8'h81);
		meas;
		near(7, 30);
		host.wr(8'h1b, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 chk({7'h00, bclk_oe}, 8'h00);
		host.wr(8'h19, 8'h00);
		host.wr(8'h1a, 8'h84);
		for (i = 0; i < 4; i = i + 1) begin
			host.wr(8'h34, 8'h04 + i[7:0]);
			repeat (4) @(posedge core_clk);
			chk({4'h0, gp_oe}, 8'h01 << i);
			meas;
			near(8, 30);
		end
		host.wr(8'h19, 8'h05);
		host.wr(8'h1a, 8'h82);
		meas;
		near(8, 10);
		host.dac_shutdown(8'h82, 8'h83);
		meas;
		near(1, 0);
		near(2, 0);
		near(4, 120);
		host.flags(1'b0, 1'b0, 1'b0);
		host.wr(8'h0b, 8'h82);
		host.wr(8'h0c, 8'h83);
		meas;
		near(3, 5);
		host.wr(8'h06, 8'h09);
		host.wr(8'h05, 8'h91);
		host.wr(8'h04, 8'h03);
		meas;
		near(0, 1080);
		near(1, 540);
		host.wr(8'h07, 8'h13);
		rchk(8'h07, 8'h13);
		meas;
		near(0, 1080);
		host.wr(8'h08, 8'h88);
		meas;
		near(0, 1140);
		rchk(8'h08, 8'h88);
		host.wr(8'h04, 8'h00);
		host.wr(8'h05, 8'h23);
		rchk(8'h05, 8'h23);
		meas;
		near(0, 0);
		test_done;
	end
endmodule // ccpll_top_bench
bind ccpll_top ccpll_checker chk (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.adc_powered_down, .dac_left_powered_down, .dac_right_powered_down, .pll_clock_en, .dac_processor_clock_en,
	.dac_modulator_clock_en, .dac_sample_en, .adc_modulator_clock_en, .adc_sample_en, .bclk_oe,
	.general_pin_one_oe, .general_pin_two_oe, .serial_audio_out_pin_oe, .spi_data_out_oe);
